// ### ppc_if.sv
// register access channel between configuring software agent and pll control
`timescale 1ns/1ps
interface ppc_if;
    logic req;
    logic wr;
    logic [ppc_pkg::ADDR_W-1:0] addr;
    logic [ppc_pkg::DATA_W-1:0] wdata;
    logic [ppc_pkg::DATA_W-1:0] rdata;
    logic ack;

    modport dev (input req, input wr, input addr, input wdata, output rdata, output ack);
    modport sw (output req, output wr, output addr, output wdata, input rdata, input ack);
endinterface

// ### ppc_pkg.sv
// shared constants, register layout and state encodings for the packet pll control
package ppc_pkg;
    // --------------------
    // register bus
    // --------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_FREQ = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_RSTSEL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_KEY_FIRST = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_KEY_SECOND = 8'h0C;
    // arbitrary key values for the write-unlock sequence
    localparam logic [DATA_W-1:0] KEY_FIRST_VALUE = 32'hA5C3_0F01;
    localparam logic [DATA_W-1:0] KEY_SECOND_VALUE = 32'h5A3C_F002;

    // --------------------
    // field layout
    // --------------------
    localparam int MUL_W = 13;
    localparam int DIV_W = 6;
    localparam int BW_W = 12;
    localparam int BW_LO_LSB = 24;
    localparam int BW_LO_W = 8;
    localparam int BYPASS_BIT = 23;
    localparam int MUL_LSB = 6;
    localparam int DIV_LSB = 0;
    localparam int PLL_RST_BIT = 14;
    localparam int OSEL_BIT = 13;
    localparam int SAT_BIT = 6;
    localparam int BW_HI_LSB = 0;
    localparam int BW_HI_W = 4;
    localparam logic [DATA_W-1:0] FREQ_RESET = 32'h0908_04C0;
    localparam logic [DATA_W-1:0] RSTSEL_RESET = 32'h0000_0000;
    // bits 5-4 of the reset/select register read as zero and ignore writes
    localparam logic [DATA_W-1:0] RSTSEL_WMASK = 32'hFFFF_FFCF;

    // --------------------
    // timing
    // --------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int RELOCK_WAIT_NS = 1000;
    localparam int RELOCK_WAIT_CYC = (RELOCK_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // --------------------
    // states
    // --------------------
    typedef enum logic [1:0] {
        UNLK_CLOSED = 2'b00,
        UNLK_HALF = 2'b01,
        UNLK_OPEN = 2'b10
    } ppc_unlock_e;

    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_ISSUE = 2'b01,
        SW_WAIT_ACK = 2'b10,
        SW_RELOCK = 2'b11
    } ppc_sw_state_e;
endpackage

// ### ppc_pll_ctrl.sv
// packet accelerator pll control: registers, unlock, clock path and reset/lock status
`timescale 1ns/1ps
// Behaviour
// - reference source chosen by select pin level
// - pll bypassed after power-on until programmed
// - software unlocks with two keys before writing
// - control registers reset only by power-on
// - software sets bandwidth to ((m+1)>>1)-1
// - freq bit 23 enables bypass
// - freq bits 18-6 set multiplier
// - freq bits 5-0 set reference divider
// - select bit 14 holds pll in reset
// - select bit 13 routes pll clock onward
// - software must set saturation enable bit
// - pll output divided by two to coprocessor
// - lock reached before status high, kept after
// - one common reset and one common powerdown
module ppc_pll_ctrl #(
    parameter logic [ppc_pkg::DATA_W-1:0] KEY_FIRST = ppc_pkg::KEY_FIRST_VALUE,
    parameter logic [ppc_pkg::DATA_W-1:0] KEY_SECOND = ppc_pkg::KEY_SECOND_VALUE
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic warm_resetn_i,
    ppc_if.dev bus,
    input wire logic ref_source_select_pin_i,
    input wire logic core_reference_clock_i,
    input wire logic accel_reference_clock_i,
    input wire logic pll_output_clock_i,
    input wire logic pll_lock_i,
    output logic pll_ref_clock_o,
    output logic pll_bypass_o,
    output logic [ppc_pkg::MUL_W-1:0] multiplier_select_o,
    output logic [ppc_pkg::DIV_W-1:0] ref_divider_select_o,
    output logic [ppc_pkg::BW_W-1:0] bandwidth_adjust_o,
    output logic saturation_enable_o,
    output logic accel_clock_output_select_o,
    output logic common_pll_reset_n_o,
    output logic common_pll_powerdown_o,
    output logic coproc_clock_o,
    output logic reset_status_output_o,
    output logic regs_unlocked_o
);
    // --------------------
    // elaboration checks
    // --------------------
    if (KEY_FIRST == KEY_SECOND) begin : g_key_check
        $error("unlock keys must differ");
    end

    // --------------------
    // declarations
    // --------------------
    logic [ppc_pkg::DATA_W-1:0] pll_freq_config;
    logic [ppc_pkg::DATA_W-1:0] pll_reset_select_config;
    ppc_pkg::ppc_unlock_e unlock_state;
    ppc_pkg::ppc_unlock_e next_unlock_state;
    logic por_bypass;
    logic eff_bypass;
    logic ref_sel;
    logic src_clk;
    logic src_q;
    logic div_q;
    logic lock_seen;
    logic wr_en;
    logic [ppc_pkg::DATA_W-1:0] next_rdata;

    assign wr_en = bus.req && bus.wr && (unlock_state == ppc_pkg::UNLK_OPEN);
    // a hardware bypass flag covers the window before software first writes the frequency register while unlocked
    assign eff_bypass = pll_freq_config[ppc_pkg::BYPASS_BIT] | por_bypass;
    assign ref_sel = ref_source_select_pin_i ? accel_reference_clock_i : core_reference_clock_i;
    assign src_clk = eff_bypass ? ref_sel : pll_output_clock_i;

    // --------------------
    // write-unlock sequence
    // --------------------
    always_comb begin
        next_unlock_state = unlock_state;
        if (bus.req && bus.wr) begin
            if (bus.addr == ppc_pkg::OFS_KEY_FIRST) begin
                next_unlock_state = (bus.wdata == KEY_FIRST) ? ppc_pkg::UNLK_HALF : ppc_pkg::UNLK_CLOSED;
            end else if (bus.addr == ppc_pkg::OFS_KEY_SECOND) begin
                if (bus.wdata == KEY_SECOND && unlock_state != ppc_pkg::UNLK_CLOSED) begin
                    next_unlock_state = ppc_pkg::UNLK_OPEN;
                end else begin
                    next_unlock_state = ppc_pkg::UNLK_CLOSED;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            unlock_state <= ppc_pkg::UNLK_CLOSED;
        end else begin
            unlock_state <= next_unlock_state;
        end
    end

    // --------------------
    // control registers, power-on reset only; warm reset never reaches them
    // --------------------
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pll_freq_config <= ppc_pkg::FREQ_RESET;
        end else if (wr_en && bus.addr == ppc_pkg::OFS_FREQ) begin
            pll_freq_config <= bus.wdata;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pll_reset_select_config <= ppc_pkg::RSTSEL_RESET;
        end else if (wr_en && bus.addr == ppc_pkg::OFS_RSTSEL) begin
            pll_reset_select_config <= bus.wdata & ppc_pkg::RSTSEL_WMASK;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            por_bypass <= 1'b1;
        end else if (wr_en && bus.addr == ppc_pkg::OFS_FREQ) begin
            por_bypass <= 1'b0;
        end
    end

    // --------------------
    // register read port
    // --------------------
    always_comb begin
        next_rdata = '0;
        unique case (bus.addr)
            ppc_pkg::OFS_FREQ: next_rdata = pll_freq_config;
            ppc_pkg::OFS_RSTSEL: next_rdata = pll_reset_select_config;
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bus.ack <= 1'b0;
            bus.rdata <= '0;
        end else begin
            bus.ack <= bus.req;
            bus.rdata <= (bus.req && !bus.wr) ? next_rdata : '0;
        end
    end

    // --------------------
    // pll pin drive
    // --------------------
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pll_bypass_o <= 1'b1;
            multiplier_select_o <= '0;
            ref_divider_select_o <= '0;
            bandwidth_adjust_o <= '0;
            saturation_enable_o <= 1'b0;
            accel_clock_output_select_o <= 1'b0;
            regs_unlocked_o <= 1'b0;
        end else begin
            pll_bypass_o <= eff_bypass;
            multiplier_select_o <= pll_freq_config[ppc_pkg::MUL_LSB +: ppc_pkg::MUL_W];
            ref_divider_select_o <= pll_freq_config[ppc_pkg::DIV_LSB +: ppc_pkg::DIV_W];
            bandwidth_adjust_o <= {pll_reset_select_config[ppc_pkg::BW_HI_LSB +: ppc_pkg::BW_HI_W],
                                   pll_freq_config[ppc_pkg::BW_LO_LSB +: ppc_pkg::BW_LO_W]};
            saturation_enable_o <= pll_reset_select_config[ppc_pkg::SAT_BIT];
            accel_clock_output_select_o <= pll_reset_select_config[ppc_pkg::OSEL_BIT];
            regs_unlocked_o <= (unlock_state == ppc_pkg::UNLK_OPEN);
        end
    end

    // one reset line and one powerdown line feed all three pll sub-blocks
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            common_pll_reset_n_o <= 1'b0;
            common_pll_powerdown_o <= 1'b1;
        end else begin
            common_pll_reset_n_o <= !pll_reset_select_config[ppc_pkg::PLL_RST_BIT];
            common_pll_powerdown_o <= 1'b0;
        end
    end

    // --------------------
    // clock path: reference out, divide by two toward the coprocessor
    // --------------------
    // clocks are sampled as levels at the system rate, so source clocks must stay below half of it
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pll_ref_clock_o <= 1'b0;
            src_q <= 1'b0;
        end else begin
            pll_ref_clock_o <= ref_sel;
            src_q <= src_clk;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_q <= 1'b0;
        end else if (!pll_reset_select_config[ppc_pkg::OSEL_BIT]) begin
            div_q <= 1'b0;
        end else if (src_clk && !src_q) begin
            div_q <= !div_q;
        end
    end

    assign coproc_clock_o = div_q;

    // --------------------
    // lock and reset status
    // --------------------
    // lock is only counted once after power-on; a warm reset drops status but not lock
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lock_seen <= 1'b0;
        end else if (pll_lock_i && common_pll_reset_n_o) begin
            lock_seen <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reset_status_output_o <= 1'b0;
        end else begin
            reset_status_output_o <= lock_seen && warm_resetn_i;
        end
    end
endmodule

// ### ppc_pll_ctrl_asserts.sv
// concurrent checks on the register channel and pll pins of the device end
`timescale 1ns/1ps
module ppc_pll_ctrl_asserts (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic warm_resetn_i,
    input wire logic req,
    input wire logic wr,
    input wire logic [ppc_pkg::ADDR_W-1:0] addr,
    input wire logic [ppc_pkg::DATA_W-1:0] rdata,
    input wire logic ack,
    input wire logic pll_lock_i,
    input wire logic ref_source_select_pin_i,
    input wire logic core_reference_clock_i,
    input wire logic accel_reference_clock_i,
    input wire logic pll_ref_clock_o,
    input wire logic [ppc_pkg::MUL_W-1:0] multiplier_select_o,
    input wire logic [ppc_pkg::DIV_W-1:0] ref_divider_select_o,
    input wire logic common_pll_reset_n_o,
    input wire logic common_pll_powerdown_o,
    input wire logic coproc_clock_o,
    input wire logic accel_clock_output_select_o,
    input wire logic reset_status_output_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    // --------------------
    // register channel
    // --------------------
    ack_after_req_a: assert property (req |=> ack) else $error("no answer one cycle after request");
    ack_needs_req_a: assert property (!req |=> !ack) else $error("answer without request");
    key_reads_zero_a: assert property (req && (wr || addr[3]) |=> rdata == '0)
        else $error("write or key answer not zero");
    // a write in the cycle before would land between register and pins, so skip it
    freq_fields_a: assert property (req && !wr && addr == ppc_pkg::OFS_FREQ && !$past(req)
        |=> rdata[18:6] == multiplier_select_o && rdata[5:0] == ref_divider_select_o) else $error("freq fields off");
    rstsel_bits_a: assert property (req && !wr && addr == ppc_pkg::OFS_RSTSEL && !$past(req)
        |=> rdata[14] != common_pll_reset_n_o && rdata[13] == accel_clock_output_select_o && rdata[5:4] == 2'b00)
        else $error("reset/select bits off");
    // --------------------
    // pll pins
    // --------------------
    ref_select_a: assert property ($past(resetn_i) |-> pll_ref_clock_o ==
        ($past(ref_source_select_pin_i) ? $past(accel_reference_clock_i) : $past(core_reference_clock_i)))
        else $error("wrong ref");
    powerdown_low_a: assert property ($past(resetn_i) |-> !common_pll_powerdown_o) else $error("powerdown high");
    no_clk_unsel_a: assert property (!accel_clock_output_select_o [*2] |-> !coproc_clock_o)
        else $error("clock while unselected");
    warm_drops_a: assert property (!warm_resetn_i |=> !reset_status_output_o) else $error("status kept");
    lock_first_a: assert property ($rose(reset_status_output_o) |-> $past(pll_lock_i))
        else $error("status before lock");
endmodule

// ### ppc_pll_ctrl_tb.sv
// self-checking bench: sequencer against device, plus a bench-driven second device
`timescale 1ns/1ps
module ppc_pll_ctrl_tb;
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin errors++; \
$display("unexpected %s exp %0h got %0h", nm, ex, gt); end end
    localparam logic [31:0] FREQ_RST = {8'h09, 1'b0, 4'h1, 13'h0013, 6'h00};
    localparam logic [31:0] FREQ_W = {8'h13, 1'b0, 4'h0, 13'h0027, 6'h01};
    localparam logic [31:0] BYP = 32'h0080_0000;
    logic sys_clk, resetn, warm_resetn, sel_pin, lock, start;
    logic [7:0] cyc = 8'h00;
    logic [12:0] mi, mul1, mul2;
    logic [5:0] di, div1, div2;
    logic [11:0] bw1, bw2;
    logic [31:0] rb, rd;
    logic co1, co1_q, co2, co2_q, byp1, byp2, rstn1, rstn2, pd1, pd2, sat1, sat2, osel1, osel2, stat1, unl2, ref1;
    logic busy, done;
    int errors, total_checks, ticks, n1, n2;
    ppc_if bus1();
    ppc_if bus2();
    ppc_sw_cfg #(.RELOCK_CYC(2)) i_ppc_sw_cfg (.sys_clk_i(sys_clk), .resetn_i(resetn), .bus(bus1), .cfg_start_i(start),
        .cfg_multiplier_i(mi), .cfg_divider_i(di), .cfg_busy_o(busy), .cfg_done_o(done), .cfg_readback_o(rb));
    ppc_pll_ctrl i_ppc_pll_ctrl (.sys_clk_i(sys_clk), .resetn_i(resetn), .warm_resetn_i(warm_resetn), .bus(bus1),
        .ref_source_select_pin_i(sel_pin), .core_reference_clock_i(cyc[3]), .accel_reference_clock_i(cyc[2]),
        .pll_output_clock_i(cyc[1]), .pll_lock_i(lock), .pll_ref_clock_o(ref1), .pll_bypass_o(byp1),
        .multiplier_select_o(mul1), .ref_divider_select_o(div1), .bandwidth_adjust_o(bw1), .saturation_enable_o(sat1),
        .accel_clock_output_select_o(osel1), .common_pll_reset_n_o(rstn1), .common_pll_powerdown_o(pd1),
        .coproc_clock_o(co1), .reset_status_output_o(stat1), .regs_unlocked_o());
    ppc_pll_ctrl i_ppc_pll_ctrl_b (.sys_clk_i(sys_clk), .resetn_i(resetn), .warm_resetn_i(warm_resetn), .bus(bus2),
        .ref_source_select_pin_i(sel_pin), .core_reference_clock_i(cyc[3]), .accel_reference_clock_i(cyc[2]),
        .pll_output_clock_i(cyc[1]), .pll_lock_i(lock), .pll_ref_clock_o(), .pll_bypass_o(byp2),
        .multiplier_select_o(mul2), .ref_divider_select_o(div2), .bandwidth_adjust_o(bw2), .saturation_enable_o(sat2),
        .accel_clock_output_select_o(osel2), .common_pll_reset_n_o(rstn2), .common_pll_powerdown_o(pd2),
        .coproc_clock_o(co2), .reset_status_output_o(), .regs_unlocked_o(unl2));
    ppc_pll_ctrl_asserts i_ppc_pll_ctrl_asserts (.sys_clk_i(sys_clk), .resetn_i(resetn), .warm_resetn_i(warm_resetn),
        .req(bus1.req), .wr(bus1.wr), .addr(bus1.addr), .rdata(bus1.rdata), .ack(bus1.ack), .pll_lock_i(lock),
        .ref_source_select_pin_i(sel_pin), .core_reference_clock_i(cyc[3]), .accel_reference_clock_i(cyc[2]),
        .pll_ref_clock_o(ref1), .multiplier_select_o(mul1), .ref_divider_select_o(div1), .common_pll_reset_n_o(rstn1),
        .common_pll_powerdown_o(pd1), .coproc_clock_o(co1), .accel_clock_output_select_o(osel1),
        .reset_status_output_o(stat1));
    // --------------------
    // clock, slow reference waveforms, toggle counters, timeout
    // --------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 8'h01;
        co1_q <= co1;
        co2_q <= co2;
        if (co1 !== co1_q) n1++;
        if (co2 !== co2_q) n2++;
        ticks++;
        if (ticks == 20000) begin
            errors++;
            complete_run();
        end
    end
    // --------------------
    // tasks
    // --------------------
    task automatic complete_run();
        if (errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // req is a one-cycle pulse; the answer is due exactly one cycle later
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus2.req <= 1'b1;
        bus2.wr <= w;
        bus2.addr <= a;
        bus2.wdata <= d;
        @(posedge sys_clk);
        bus2.req <= 1'b0;
        @(posedge sys_clk);
        `CHK("ack", 1'b1, bus2.ack)
        rd = bus2.rdata;
    endtask
    // counts are windowed, so one edge either side is tolerated
    task automatic span(input logic inst2, input int lo, input int hi);
        int a;
        a = inst2 ? n2 : n1;
        repeat (64) @(posedge sys_clk);
        a = (inst2 ? n2 : n1) - a;
        `CHK("clock toggles", 1'b1, a >= lo && a <= hi)
    endtask
    task automatic t_reset_vals();
        acc(1'b0, ppc_pkg::OFS_FREQ, 32'h0);
        `CHK("freq", FREQ_RST, rd)
        acc(1'b0, ppc_pkg::OFS_RSTSEL, 32'h0);
        `CHK("rstsel", 32'h0, rd)
        acc(1'b0, 8'h10, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        `CHK("bypass", 1'b1, byp2)
        `CHK("pll rst_n", 1'b1, rstn2)
        `CHK("pwrdn", 1'b0, pd2)
    endtask
    task automatic t_locked_write();
        acc(1'b1, ppc_pkg::OFS_FREQ, FREQ_W);
        acc(1'b1, ppc_pkg::OFS_KEY_FIRST, ppc_pkg::KEY_FIRST_VALUE ^ 32'h1);
        acc(1'b1, ppc_pkg::OFS_KEY_SECOND, ppc_pkg::KEY_SECOND_VALUE);
        acc(1'b1, ppc_pkg::OFS_FREQ, FREQ_W);
        acc(1'b0, ppc_pkg::OFS_FREQ, 32'h0);
        `CHK("locked freq", FREQ_RST, rd)
        `CHK("unlocked", 1'b0, unl2)
    endtask
    task automatic t_unlocked();
        acc(1'b1, ppc_pkg::OFS_KEY_FIRST, ppc_pkg::KEY_FIRST_VALUE);
        acc(1'b1, ppc_pkg::OFS_KEY_SECOND, ppc_pkg::KEY_SECOND_VALUE);
        acc(1'b1, ppc_pkg::OFS_FREQ, FREQ_W);
        acc(1'b1, ppc_pkg::OFS_RSTSEL, 32'hFFFF_FFFF);
        acc(1'b0, ppc_pkg::OFS_FREQ, 32'h0);
        `CHK("freq", FREQ_W, rd)
        acc(1'b0, ppc_pkg::OFS_RSTSEL, 32'h0);
        `CHK("rstsel", 32'hFFFF_FFCF, rd)
        `CHK("mul", 13'h0027, mul2)
        `CHK("div", 6'h01, div2)
        `CHK("bw", 12'hF13, bw2)
        `CHK("bypass", 1'b0, byp2)
        `CHK("pll rst_n", 1'b0, rstn2)
        `CHK("osel", 1'b1, osel2)
        `CHK("sat", 1'b1, sat2)
    endtask
    task automatic t_bypass_ref();
        acc(1'b1, ppc_pkg::OFS_FREQ, FREQ_W | BYP);
        sel_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        `CHK("bypass", 1'b1, byp2)
        span(1'b1, 7, 9);
        sel_pin <= 1'b0;
        repeat (4) @(posedge sys_clk);
        span(1'b1, 3, 5);
    endtask
    task automatic t_sequence();
        int k;
        mi <= 13'h0027;
        di <= 6'h01;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        for (k = 0; k < 400 && done !== 1'b1; k++) @(posedge sys_clk);
        `CHK("done", 1'b1, done)
        `CHK("busy", 1'b0, busy)
        `CHK("rb bw", 8'h13, rb[31:24])
        `CHK("rb bypass", 1'b0, rb[23])
        `CHK("rb mul", 13'h0027, rb[18:6])
        `CHK("rb div", 6'h01, rb[5:0])
        repeat (2) @(posedge sys_clk);
        `CHK("bw", 12'h013, bw1)
        `CHK("sat", 1'b1, sat1)
        `CHK("osel", 1'b1, osel1)
        `CHK("pll rst_n", 1'b1, rstn1)
        `CHK("bypass", 1'b0, byp1)
        span(1'b0, 15, 17);
        lock <= 1'b1;
        for (k = 0; k < 50 && stat1 !== 1'b1; k++) @(posedge sys_clk);
        `CHK("status", 1'b1, stat1)
        warm_resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        `CHK("status warm", 1'b0, stat1)
        warm_resetn <= 1'b1;
        acc(1'b0, ppc_pkg::OFS_FREQ, 32'h0);
        `CHK("freq warm", FREQ_W | BYP, rd)
    endtask
    // --------------------
    // main sequence
    // --------------------
    initial begin
        resetn = 1'b0;
        warm_resetn = 1'b1;
        sel_pin = 1'b0;
        lock = 1'b0;
        start = 1'b0;
        mi = 13'h0000;
        di = 6'h00;
        bus2.req = 1'b0;
        bus2.wr = 1'b0;
        bus2.addr = 8'h00;
        bus2.wdata = 32'h0;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset_vals();
        t_locked_write();
        t_unlocked();
        t_bypass_ref();
        t_sequence();
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        acc(1'b0, ppc_pkg::OFS_FREQ, 32'h0);
        `CHK("freq por", FREQ_RST, rd)
        `CHK("unlocked por", 1'b0, unl2)
        complete_run();
    end
endmodule

// ### ppc_sw_cfg.sv
// configuring agent: unlocks and programs the pll control registers in order
`timescale 1ns/1ps
module ppc_sw_cfg #(
    parameter int RELOCK_CYC = ppc_pkg::RELOCK_WAIT_CYC
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    ppc_if.sw bus,
    input wire logic cfg_start_i,
    input wire logic [ppc_pkg::MUL_W-1:0] cfg_multiplier_i,
    input wire logic [ppc_pkg::DIV_W-1:0] cfg_divider_i,
    output logic cfg_busy_o,
    output logic cfg_done_o,
    output logic [ppc_pkg::DATA_W-1:0] cfg_readback_o
);
    // --------------------
    // checks and declarations
    // --------------------
    if (RELOCK_CYC < 1 || RELOCK_CYC > 65535) begin : g_relock_check
        $error("relock wait out of range");
    end

    localparam logic [2:0] STEP_RELOCK = 3'h5;
    localparam logic [2:0] STEP_LAST = 3'h7;

    ppc_pkg::ppc_sw_state_e state;
    logic [2:0] step;
    logic [15:0] wait_cnt;
    logic [ppc_pkg::MUL_W-1:0] mul_q;
    logic [ppc_pkg::DIV_W-1:0] div_q;
    logic [ppc_pkg::BW_W-1:0] bw;
    logic [ppc_pkg::DATA_W-1:0] freq_word;
    logic [ppc_pkg::DATA_W-1:0] rstsel_word;
    logic [ppc_pkg::ADDR_W-1:0] step_addr;
    logic [ppc_pkg::DATA_W-1:0] step_data;
    logic step_wr;

    // bandwidth from the multiplier: ((m+1)>>1)-1
    assign bw = ppc_pkg::BW_W'((({1'b0, mul_q} + 14'h0001) >> 1) - 14'h0001);

    always_comb begin
        freq_word = '0;
        freq_word[ppc_pkg::BW_LO_LSB +: ppc_pkg::BW_LO_W] = bw[ppc_pkg::BW_LO_W-1:0];
        freq_word[ppc_pkg::MUL_LSB +: ppc_pkg::MUL_W] = mul_q;
        freq_word[ppc_pkg::DIV_LSB +: ppc_pkg::DIV_W] = div_q;
        rstsel_word = '0;
        rstsel_word[ppc_pkg::BW_HI_LSB +: ppc_pkg::BW_HI_W] = bw[ppc_pkg::BW_W-1:ppc_pkg::BW_LO_W];
        rstsel_word[ppc_pkg::SAT_BIT] = 1'b1;
        rstsel_word[ppc_pkg::OSEL_BIT] = 1'b1;
    end

    // --------------------
    // step table: unlock, hold in reset, program bypassed, release, leave bypass
    // --------------------
    always_comb begin
        step_addr = ppc_pkg::OFS_FREQ;
        step_data = '0;
        step_wr = 1'b1;
        unique case (step)
            3'h0: begin
                step_addr = ppc_pkg::OFS_KEY_FIRST;
                step_data = ppc_pkg::KEY_FIRST_VALUE;
            end
            3'h1: begin
                step_addr = ppc_pkg::OFS_KEY_SECOND;
                step_data = ppc_pkg::KEY_SECOND_VALUE;
            end
            3'h2: begin
                step_addr = ppc_pkg::OFS_RSTSEL;
                step_data = rstsel_word | (32'h1 << ppc_pkg::PLL_RST_BIT);
            end
            3'h3: begin
                step_data = freq_word | (32'h1 << ppc_pkg::BYPASS_BIT);
            end
            3'h4: begin
                step_addr = ppc_pkg::OFS_RSTSEL;
                step_data = rstsel_word;
            end
            3'h5: begin
                step_wr = 1'b0;
            end
            3'h6: begin
                step_data = freq_word;
            end
            3'h7: begin
                step_wr = 1'b0;
            end
        endcase
    end

    // --------------------
    // sequencer
    // --------------------
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= ppc_pkg::SW_IDLE;
            step <= '0;
            wait_cnt <= '0;
            mul_q <= '0;
            div_q <= '0;
            bus.req <= 1'b0;
            bus.wr <= 1'b0;
            bus.addr <= '0;
            bus.wdata <= '0;
            cfg_busy_o <= 1'b0;
            cfg_done_o <= 1'b0;
            cfg_readback_o <= '0;
        end else begin
            bus.req <= 1'b0;
            cfg_done_o <= 1'b0;
            unique case (state)
                ppc_pkg::SW_IDLE: begin
                    if (cfg_start_i) begin
                        mul_q <= cfg_multiplier_i;
                        div_q <= cfg_divider_i;
                        step <= '0;
                        cfg_busy_o <= 1'b1;
                        state <= ppc_pkg::SW_ISSUE;
                    end
                end
                ppc_pkg::SW_ISSUE: begin
                    if (step == STEP_RELOCK) begin
                        wait_cnt <= 16'(RELOCK_CYC - 1);
                        state <= ppc_pkg::SW_RELOCK;
                    end else begin
                        bus.req <= 1'b1;
                        bus.wr <= step_wr;
                        bus.addr <= step_addr;
                        bus.wdata <= step_wr ? step_data : '0;
                        state <= ppc_pkg::SW_WAIT_ACK;
                    end
                end
                ppc_pkg::SW_WAIT_ACK: begin
                    if (bus.ack) begin
                        if (step == STEP_LAST) begin
                            cfg_readback_o <= bus.rdata;
                            cfg_busy_o <= 1'b0;
                            cfg_done_o <= 1'b1;
                            state <= ppc_pkg::SW_IDLE;
                        end else begin
                            step <= step + 3'h1;
                            state <= ppc_pkg::SW_ISSUE;
                        end
                    end
                end
                ppc_pkg::SW_RELOCK: begin
                    if (wait_cnt == '0) begin
                        step <= step + 3'h1;
                        state <= ppc_pkg::SW_ISSUE;
                    end else begin
                        wait_cnt <= wait_cnt - 16'h0001;
                    end
                end
            endcase
        end
    end
endmodule
